// ===== logic/xdec_addr_calc.sv
`timescale 1ns/1ns
module xdec_addr_calc (
	xdec_addr_if.calc a
);
	always_comb begin
		if (!a.acc_bit && a.ext_on && a.f_addr <= xdec_pkg::INDEX_LIMIT)
			a.eff_addr = a.ptr2 + {4'h0, a.f_addr};  // RQ5
		else if (a.acc_bit)
			a.eff_addr = {a.bank_sel, a.f_addr};  // RQ4
		else if (a.f_addr < xdec_pkg::ACCESS_SPLIT)
			a.eff_addr = {4'h0, a.f_addr};  // RQ4
		else
			a.eff_addr = {xdec_pkg::ACCESS_HI_BNK, a.f_addr};
	end
endmodule

// ===== logic/xdec_addr_if.sv
`timescale 1ns/1ns
interface xdec_addr_if;
	logic [7:0]  f_addr;
	logic        acc_bit;
	logic        ext_on;
	logic [3:0]  bank_sel;
	logic [11:0] ptr2;
	logic [11:0] eff_addr;
	modport core (output f_addr, acc_bit, ext_on, bank_sel, ptr2, input eff_addr);
	modport calc (input f_addr, acc_bit, ext_on, bank_sel, ptr2, output eff_addr);
endinterface

// ===== logic/xdec_core.sv
`timescale 1ns/1ns
// Purpose: executes skip-if-zero test, both xor forms and pointer add/sub(+return)
// Assumes: one i_word per instruction cycle when i_ce high; file read is combinational
// Notes: unprogrammed fuse strap is i_fuse_ext; a clear fuse makes extended words nops
//        a return flushes exactly one word; only a taken skip may stretch over a pair
//        i_ce low freezes every register, pulses included
module xdec_core #(
	parameter int PTR_W = 12
) (
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic             i_fuse_ext,
	input  wire logic [15:0]      i_word,
	input  wire logic [3:0]       i_bank_sel,
	input  wire logic [7:0]       i_file_rdata,
	input  wire logic [20:0]      i_stack_top,
	output logic      [11:0]      o_file_addr,
	output logic      [7:0]       o_file_wdata,
	output logic                  o_file_we,
	output logic      [7:0]       o_acc,
	output logic                  o_flag_n,
	output logic                  o_flag_z,
	output logic      [20:0]      o_pc_load,
	output logic                  o_pc_load_en,
	output logic                  o_pop,
	output logic                  o_discard,
	output logic      [PTR_W-1:0] o_ptr0,
	output logic      [PTR_W-1:0] o_ptr1,
	output logic      [PTR_W-1:0] o_ptr2
);
	xdec_pkg::exec_state_type st_q;
	xdec_pkg::exec_state_type st_d;
	logic [PTR_W-1:0]         ptr_q [3];
	logic [7:0]               acc_q;
	logic                     fuse_q;
	logic                     from_test_q;
	logic                     live;
	logic                     is_tst;
	logic                     is_xlit;
	logic                     is_xfile;
	logic                     is_ptr;
	logic                     is_ret;
	logic                     skip_next;
	logic                     flush_start;
	logic                     pair_next;
	logic [7:0]               xor_operand;
	logic [7:0]               xres;
	logic [1:0]               ptr_sel;
	logic [PTR_W-1:0]         ptr_next;
	xdec_addr_if              ai ();

	function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p, input logic sub, input logic [5:0] k);
		ptr_step = sub ? p - PTR_W'(k) : p + PTR_W'(k);
	endfunction

	assign live        = i_ce && st_q == xdec_pkg::ST_EXEC;
	assign is_tst      = i_word[15:10] == xdec_pkg::OP_TEST_SKIP_HI && i_word[9];  // RQ1
	assign is_xlit     = i_word[15:8] == xdec_pkg::OP_XORLIT;  // RQ6
	assign is_xfile    = i_word[15:10] == xdec_pkg::OP_XORFILE;  // RQ7
	assign is_ptr      = i_word[15:9] == xdec_pkg::OP_PTR_ADDSUB && fuse_q;  // RQ9 RQ10
	assign is_ret      = is_ptr && i_word[7:6] == 2'b11;  // RQ11
	assign xor_operand = is_xlit ? i_word[7:0] : i_file_rdata;
	assign xres        = acc_q ^ xor_operand;
	assign skip_next   = is_tst && i_file_rdata == 8'h00;  // RQ2
	assign flush_start = live && (skip_next || is_ret);
	assign pair_next   = from_test_q && i_word[15:12] == xdec_pkg::OP_TWO_WORD;  // RQ3
	assign ptr_sel     = is_ret ? 2'd2 : i_word[7:6];
	assign ptr_next    = ptr_step(ptr_q[ptr_sel], i_word[8], i_word[5:0]);

	assign ai.f_addr   = i_word[7:0];
	assign ai.acc_bit  = i_word[8];
	assign ai.ext_on   = fuse_q;
	assign ai.bank_sel = i_bank_sel;
	assign ai.ptr2     = ptr_q[2];
	xdec_addr_calc u_addr (.a(ai));

	// strap caught on a clocked reset so it is never an async load
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			fuse_q <= i_fuse_ext;  // RQ9
		end
	end

	// a return flushes one word only, so remember who opened the flush
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			from_test_q <= 1'b0;
		end else if (live) begin
			from_test_q <= skip_next;
		end
	end

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			xdec_pkg::ST_EXEC: begin
				if (skip_next || is_ret) begin
					st_d = xdec_pkg::ST_SKIP1;  // RQ2 RQ13
				end
			end
			xdec_pkg::ST_SKIP1: begin
				if (pair_next) begin
					st_d = xdec_pkg::ST_SKIP2;  // RQ3
				end else begin
					st_d = xdec_pkg::ST_EXEC;
				end
			end
			xdec_pkg::ST_SKIP2: begin
				st_d = xdec_pkg::ST_EXEC;  // RQ3
			end
			default: begin
				st_d = xdec_pkg::ST_EXEC;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			st_q <= xdec_pkg::ST_EXEC;
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end

	// the second word of a two-word instruction starts 1111, so a skipped pair
	// is recognised from the word flushed in the first nop cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_discard <= 1'b0;
		end else if (i_ce) begin
			o_discard <= flush_start;  // RQ2 RQ13
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			acc_q    <= 8'h00;
			o_flag_n <= 1'b0;
			o_flag_z <= 1'b0;
		end else if (live && (is_xlit || is_xfile)) begin
			if (is_xlit || !i_word[9]) begin
				acc_q <= xres;  // RQ6 RQ8
			end
			o_flag_z <= xres == 8'h00;  // RQ14
			o_flag_n <= xres[7];  // RQ14
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_file_we    <= 1'b0;
			o_file_wdata <= 8'h00;
			o_file_addr  <= 12'h000;
		end else if (i_ce) begin
			o_file_addr  <= ai.eff_addr;  // RQ4 RQ5
			o_file_wdata <= xres;
			o_file_we    <= live && is_xfile && i_word[9];  // RQ8
		end
	end

	// pointer field 11 is the return form and never touches a fourth pointer
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			for (int i = 0; i < 3; i++) begin
				ptr_q[i] <= '0;
			end
		end else if (live && is_ptr) begin
			if (is_ret) begin
				ptr_q[2] <= ptr_next;  // RQ11
			end else if (i_word[7:6] != 2'b11) begin
				ptr_q[i_word[7:6]] <= ptr_next;  // RQ12
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			o_pc_load_en <= 1'b0;
			o_pop        <= 1'b0;
			o_pc_load    <= 21'h0;
		end else if (i_ce) begin
			o_pc_load_en <= live && is_ret;  // RQ13
			o_pop        <= live && is_ret;
			o_pc_load    <= i_stack_top;
		end
	end

	assign o_acc  = acc_q;
	assign o_ptr0 = ptr_q[0];
	assign o_ptr1 = ptr_q[1];
	assign o_ptr2 = ptr_q[2];
endmodule

// ===== logic/xdec_pkg.sv
// Purpose: constants shared by the test/xor/extension decoder
// Assumes: 16-bit opcode words, 8-bit data, 12-bit pointers
// Notes: bank addresses are 12 bits: bank number then 8-bit offset
//
// Contract
// RQ1: decode test-file-skip-zero from 0110 011a plus file address; flags untouched
// RQ2: tested file zero discards prefetched word, one nop cycle, two cycles total
// RQ3: skip over a two-word instruction takes three cycles, both words discarded
// RQ4: access bit 0 picks access bank, 1 picks bank register's general bank
// RQ5: access bit 0 with extension on indexes from third pointer when address <= 5fh
// RQ6: 0000 1010 literal xor into accumulator, one cycle, n and z updated
// RQ7: 0001 10da file xor with accumulator, one cycle, n and z updated
// RQ8: destination bit 0 writes accumulator, 1 writes back to file register
// RQ9: extended instructions run only when fuse enables; fuse clear by default
// RQ10: extension adds eight instructions for pointer work and indexing
// RQ11: add and subtract pointer variants on third pointer return automatically
// RQ12: pointer add adds unsigned six-bit literal to selected pointer, one cycle
// RQ13: add-and-return takes two cycles, loads pc from stack top, nop second
// RQ14: zero flag when xor result all zero, negative equals result bit seven
package xdec_pkg;
	localparam logic [5:0]  OP_TEST_SKIP_HI = 6'h19;  // 0110 01 prefix, bit9 must be 1
	localparam logic [7:0]  OP_XORLIT     = 8'h0a;
	localparam logic [5:0]  OP_XORFILE    = 6'h06;
	localparam logic [6:0]  OP_PTR_ADDSUB = 7'h74;  // 1110 100s
	localparam logic [3:0]  OP_TWO_WORD   = 4'hf;   // second-word marker nibble
	localparam logic [7:0]  INDEX_LIMIT   = 8'h5f;
	localparam logic [3:0]  ACCESS_HI_BNK = 4'hf;
	localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
	localparam logic        FUSE_DEFAULT  = 1'b0;
	localparam logic [15:0] NOP_WORD      = 16'h0000;

	typedef enum logic [1:0] {
		ST_EXEC  = 2'b00,
		ST_SKIP1 = 2'b01,
		ST_SKIP2 = 2'b11
	} exec_state_type;
endpackage

// ===== testbench/test_xdec_core.sv
// Purpose: random run of xdec_core against a bench model
// Assumes: i_ce random, mostly high
// Notes: a return ignores one word, a skip one or two
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module test_xdec_core;
	logic i_mclk, i_rst = 1'h1, i_fuse_ext = 1'h0, o_file_we, o_flag_n, o_flag_z, o_pc_load_en, o_pop, o_discard;
	logic fz, n, z, we, pl, ds, fa, ig, i_ce = 1'h1;
	logic [15:0] i_word = 16'h0;
	logic [7:0] i_file_rdata = 8'h0, o_file_wdata, o_acc, acc, x;
	logic [3:0] i_bank_sel = 4'h0;
	logic [20:0] i_stack_top = 21'h0, o_pc_load, pc;
	logic [11:0] o_file_addr, o_ptr0, o_ptr1, o_ptr2, ea, p[3];
	bit [31:0] sd = 5;
	int n_mismatch = 0, checks = 0, sk, k;
	xdec_core dut (.*);
	initial begin
		i_mclk = 0;
		forever #4 i_mclk = ~i_mclk;
	end
	function automatic bit [31:0] xs();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction
	task automatic step();
		bit [31:0] r;
		logic [15:0] w;
		logic [7:0] d;
		logic c;
		r = xs();
		c = r[15:13] != 3'h0;
		case (r[18:16])
			0: w = {7'h33, r[8:0]};
			1: w = {8'h0a, r[7:0]};
			2, 3: w = {6'h06, r[9:0]};
			4, 5: w = {7'h74, r[8:0]};
			default: w = {4'hf, r[11:0]};
		endcase
		d = r[19] ? 8'h0 : r[27:20];
		@(posedge i_mclk);
		i_word <= w;
		i_file_rdata <= d;
		i_bank_sel <= r[31:28];
		i_stack_top <= r[28:8];
		i_ce <= c;
		@(negedge i_mclk);
		`CHK({o_acc, o_flag_n, o_flag_z}, {acc, n, z})
		`CHK({o_file_we, o_pc_load_en, o_pop}, {we, pl, pl})
		if (we) `CHK(o_file_wdata, x)
		if (fa) `CHK(o_file_addr, ea)
		`CHK(o_discard, ds)
		if (pl) `CHK(o_pc_load, pc)
		`CHK({o_ptr0, o_ptr1, o_ptr2}, {p[0], p[1], p[2]})
		if (!c) return;
		ig = sk != 0;
		{we, pl, ds, fa} = 4'h0;
		pc = r[28:8];
		ea = !w[8] && fz && w[7:0] <= 8'h5f ? p[2] + w[7:0] : {w[8] ? r[31:28] : {4{w[7:0] > 8'h5f}}, w[7:0]};
		if (ig) sk = sk == 1 && w[15:12] == 4'hf ? 2 : 0;
		else if (w[15:9] == 7'h33) begin
			fa = 1;
			ds = d == 8'h0;
			sk = ds;
		end else if (w[15:8] == 8'h0a || w[15:10] == 6'h06) begin
			fa = w[12];
			x = acc ^ (w[12] ? d : w[7:0]);
			{n, z} = {x[7], x == 8'h0};
			we = w[12] & w[9];
			if (!we) acc = x;
		end else if (w[15:9] == 7'h74 && fz) begin
			pl = &w[7:6];
			ds = pl;
			sk = pl ? 3 : 0;
			k = pl ? 2 : w[7:6];
			p[k] = w[8] ? p[k] - w[5:0] : p[k] + w[5:0];
		end
	endtask
	task automatic run(input logic f);
		@(posedge i_mclk);
		i_rst <= 1'h1;
		i_fuse_ext <= f;
		i_ce <= 1'h1;
		i_word <= 16'h0;
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'h0;
		fz = f;
		{acc, n, z, we, pl, ds, fa, ig} = '0;
		sk = 0;
		p = '{0, 0, 0};
		repeat (400) step();
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		run(1'h0);
		run(1'h1);
		close_out();
	end
endmodule

// ===== testbench/xdec_core_sva.sv
// Purpose: port checks for xdec_core
// Assumes: i_ce may drop; a word counts only with i_ce high
// Notes: cycles right after a discard are left alone, a weaker but safe guard
`timescale 1ns/1ns
module xdec_core_sva #(parameter int PTR_W = 12) (
	input wire logic i_mclk, i_rst, i_ce, i_fuse_ext, o_file_we, o_flag_n, o_flag_z, o_pc_load_en, o_pop, o_discard,
	input wire logic [15:0] i_word,
	input wire logic [7:0] i_file_rdata, o_file_wdata, o_acc,
	input wire logic [3:0] i_bank_sel,
	input wire logic [20:0] i_stack_top, o_pc_load,
	input wire logic [11:0] o_file_addr,
	input wire logic [PTR_W-1:0] o_ptr2
);
	logic fz_q, dq, ex, lit, xf, fl, ix, ret;
	always_ff @(posedge i_mclk) if (i_rst) fz_q <= i_fuse_ext;
	always_ff @(posedge i_mclk) if (i_rst) dq <= 1'b0; else if (i_ce) dq <= o_discard;
	assign ex = i_ce && !o_discard && !dq;
	assign lit = ex && i_word[15:8] == 8'h0a;
	assign xf = ex && i_word[15:10] == 6'h06;
	assign fl = xf || ex && i_word[15:9] == 7'h33;
	assign ix = fl && !i_word[8] && fz_q && i_word[7:0] <= 8'h5f;
	assign ret = ex && i_word[15:9] == 7'h74 && &i_word[7:6];
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_xor_lit: assert property (lit |=> o_acc == ($past(o_acc) ^ $past(i_word[7:0])))
		else $error("xor literal");
	a_xor_flags: assert property (lit |=> o_flag_z == !o_acc && o_flag_n == o_acc[7])
		else $error("flags");
	a_file_back: assert property (xf && i_word[9] |=> o_file_we && o_file_wdata == $past(o_acc ^ i_file_rdata))
		else $error("xor file");
	a_test_skip: assert property (fl && !xf |=> o_discard == !$past(i_file_rdata) && $stable(o_flag_z))
		else $error("skip");
	a_bank_sel: assert property (fl && i_word[8] |=> o_file_addr == {$past(i_bank_sel), $past(i_word[7:0])})
		else $error("bank");
	a_index_addr: assert property (ix |=> o_file_addr == $past(o_ptr2 + i_word[7:0]))
		else $error("index");
	a_ret_pop: assert property (ret && fz_q |=> o_pop && o_pc_load_en && o_pc_load == $past(i_stack_top))
		else $error("return");
	a_fuse_off: assert property (ret && !fz_q |=> !o_pop && $stable(o_ptr2))
		else $error("fuse");
	cover property (fl ##1 o_discard);
	cover property (ret && fz_q);
	cover property (ix);
endmodule
bind xdec_core xdec_core_sva #(.PTR_W(PTR_W)) chk (.*);
